//--- hw/wcr_bridge.sv
// Wire-to-I2C bridge: write continuation, write with stop, read with stop
// Behaviour
// - Write continuation packet: command, length, data, CRC16 over all; no address.
// - Length byte counts data bytes, 1 to 255.
// - Zero length or count raises error pin, ignores link until link reset.
// - 78h writes data then stop; 69h writes data only.
// - 87h issues start, address with read bit, reads count bytes, stop.
// - Read packet: command, address, count, CRC16 over these; count 1 to 255.
// - Link commands and data are rejected while I2C executes.
// - Poll slots read zero once I2C communication completes.
// - Busy output pin shows I2C execution in progress.
// - Writes offer status byte then write status byte.
// - Reads offer status byte then exactly count data bytes.
// - Status bits: CRC, address nack, bad start; error pin while any set.
// - Write status is 00h, ordinal of the unacknowledged data byte, or FFh on CRC, address nack or bad start.
// - CRC failure starts no I2C and gives write status FFh.
// - 5Ah issues start, address with write bit, data, no stop.
`default_nettype none

// Result FIFO; the pump stalls on in_ready so the host side can throttle
module wcr_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW + 1)'(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// Honest full and empty from the occupancy count
	assign in_ready = cnt_r != FULL;
	assign out_valid = cnt_r != '0;
	assign out_data = mem[rp_r];

	// Storage has no reset; only pointers and count are controlled
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys) begin
		if (rst || flush) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
			if (push && !pop) cnt_r <= cnt_r + 1'b1;
			else if (pop && !push) cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule : wcr_fifo

module wcr_bridge (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link_reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic poll_bit,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic busy_out,
	output logic error_detected_out
);
	wcr_pkg::wcr_state_e state_r;
	logic [7:0] buf_mem [0:wcr_pkg::BUF_DEPTH-1];
	logic [7:0] cmd_r, addr_r, len_r, cnt_r, sh_r, status_r, wstat_r, qcnt_r;
	logic [15:0] crc_r;
	logic [1:0] phase_r;
	logic [3:0] bit_r;
	logic [8:0] pcnt_r;
	logic rd_r, nack_r, addr_ph_r, err_r, busy_r;
	logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, scl_lo_r, sda_lo_r;
	logic fifo_ready;

	// CRC16 byte update, low bit first
	function automatic logic [15:0] crc_upd(input logic [15:0] c,
			input logic [7:0] d);
		logic [15:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			if (x[0] ^ d[i]) x = (x >> 1) ^ wcr_pkg::CRC_POLY;
			else x = x >> 1;
		end
		return x;
	endfunction : crc_upd

	// Decode of the current command and engine conditions
	wire [15:0] crc_nxt = crc_upd(crc_r, rx_data);
	wire is_rd = cmd_r == wcr_pkg::CMD_RD_STOP;
	wire rx_rd = rx_data == wcr_pkg::CMD_RD_STOP;
	wire rx_wa = rx_data == wcr_pkg::CMD_WR_NOSTOP;
	wire rx_cont = rx_data == wcr_pkg::CMD_WR_CONT ||
		rx_data == wcr_pkg::CMD_WR_STOP;
	wire cmd_ok = rx_rd || rx_wa || rx_cont;
	wire exec = state_r == wcr_pkg::S_START || state_r == wcr_pkg::S_BYTE ||
		state_r == wcr_pkg::S_STOP;
	wire tick = qcnt_r == wcr_pkg::QTR_LAST;
	// Clock stretching: sampling waits until SCL is really seen high
	wire step = exec && tick && !(phase_r == wcr_pkg::Q2 && !scl_s_r);
	wire [7:0] cnt_inc = cnt_r + wcr_pkg::BYTE_ONE;
	wire last = cnt_inc == len_r;
	wire byte_end = step && state_r == wcr_pkg::S_BYTE &&
		phase_r == wcr_pkg::Q3 && bit_r == wcr_pkg::BIT_ACK;
	wire rd_done = byte_end && rd_r && !addr_ph_r;
	wire buf_we = (state_r == wcr_pkg::S_DATA && rx_valid) || rd_done;
	wire [7:0] buf_wd = rd_done ? sh_r : rx_data;
	wire [8:0] pump_total = is_rd ? {1'b0, len_r} + wcr_pkg::PCNT_ONE :
		wcr_pkg::WR_RESULT_LEN;
	wire [8:0] pidx = pcnt_r - wcr_pkg::PCNT_ONE;
	wire [7:0] pump_word = pcnt_r == wcr_pkg::PCNT_ZERO ? status_r :
		(is_rd ? buf_mem[pidx[7:0]] : wstat_r);
	wire pump_valid = state_r == wcr_pkg::S_PUMP;
	wire pump_last = pcnt_r == pump_total - wcr_pkg::PCNT_ONE;
	wire link_rst_ok = link_reset && !exec;

	// Open-drain pins: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_lo_r;
	assign sda_oe = sda_lo_r;
	assign busy_out = busy_r;
	assign poll_bit = busy_r;
	assign error_detected_out = err_r;

	// Pin synchronisers
	always_ff @(posedge clk_sys) begin
		scl_m_r <= scl_in;
		scl_s_r <= scl_m_r;
		sda_m_r <= sda_in;
		sda_s_r <= sda_m_r;
	end

	// Packet data and received read bytes share one buffer
	always_ff @(posedge clk_sys) begin
		if (buf_we) buf_mem[cnt_r] <= buf_wd;
	end

	// Busy flag and quarter-bit timer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_r <= 1'b0;
			qcnt_r <= 8'h00;
		end else begin
			busy_r <= exec;
			qcnt_r <= (!exec || tick) ? 8'h00 : qcnt_r + 8'h01;
		end
	end

	// Main sequencer: packet parse, I2C execution, result pump
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= wcr_pkg::S_IDLE;
			{cmd_r, addr_r, len_r, cnt_r, sh_r} <= '0;
			status_r <= wcr_pkg::STATUS_CLR;
			wstat_r <= wcr_pkg::WSTAT_OK;
			crc_r <= wcr_pkg::CRC_INIT;
			{phase_r, bit_r, pcnt_r} <= '0;
			{rd_r, nack_r, addr_ph_r, err_r, scl_lo_r, sda_lo_r} <= '0;
		end else if (link_rst_ok) begin
			state_r <= wcr_pkg::S_IDLE;
			err_r <= 1'b0;
		end else begin
			if (step) phase_r <= phase_r + 2'h1;
			unique case (state_r)
			wcr_pkg::S_IDLE: if (rx_valid && cmd_ok) begin
				cmd_r <= rx_data;
				crc_r <= crc_upd(wcr_pkg::CRC_INIT, rx_data);
				status_r <= wcr_pkg::STATUS_CLR;
				wstat_r <= wcr_pkg::WSTAT_OK;
				cnt_r <= 8'h00;
				pcnt_r <= wcr_pkg::PCNT_ZERO;
				// Continuations carry no address byte
				state_r <= rx_cont ? wcr_pkg::S_LEN : wcr_pkg::S_ADDR;
			end
			wcr_pkg::S_ADDR: if (rx_valid) begin
				// Direction bit forced from the command
				addr_r <= {rx_data[7:1], is_rd};
				crc_r <= crc_nxt;
				state_r <= wcr_pkg::S_LEN;
			end
			wcr_pkg::S_LEN: if (rx_valid) begin
				if (rx_data == wcr_pkg::LEN_ZERO) begin
					err_r <= 1'b1;
					state_r <= wcr_pkg::S_HALT;
				end else begin
					len_r <= rx_data;
					crc_r <= crc_nxt;
					state_r <= is_rd ? wcr_pkg::S_CRC_LO : wcr_pkg::S_DATA;
				end
			end
			wcr_pkg::S_DATA: if (rx_valid) begin
				crc_r <= crc_nxt;
				cnt_r <= last ? 8'h00 : cnt_inc;
				if (last) state_r <= wcr_pkg::S_CRC_LO;
			end
			wcr_pkg::S_CRC_LO: if (rx_valid) begin
				crc_r <= crc_nxt;
				state_r <= wcr_pkg::S_CRC_HI;
			end
			wcr_pkg::S_CRC_HI: if (rx_valid) begin
				phase_r <= wcr_pkg::Q0;
				bit_r <= wcr_pkg::BIT_FIRST;
				rd_r <= 1'b0;
				if (crc_nxt != wcr_pkg::CRC_RESID) begin
					status_r[wcr_pkg::ST_CRC] <= 1'b1;
					wstat_r <= wcr_pkg::WSTAT_BAD;
					err_r <= 1'b1;
					state_r <= wcr_pkg::S_PUMP;
				end else if (!is_rd && cmd_r != wcr_pkg::CMD_WR_NOSTOP) begin
					// Open transaction assumed; no start, no address
					sh_r <= buf_mem[0];
					addr_ph_r <= 1'b0;
					state_r <= wcr_pkg::S_BYTE;
				end else begin
					state_r <= wcr_pkg::S_START;
				end
			end
			// Start or repeated start from either SCL level
			wcr_pkg::S_START: if (step) begin
				unique case (phase_r)
				wcr_pkg::Q0: sda_lo_r <= 1'b0;
				wcr_pkg::Q1: scl_lo_r <= 1'b0;
				wcr_pkg::Q2: if (!sda_s_r) begin
					status_r[wcr_pkg::ST_START] <= 1'b1;
					wstat_r <= wcr_pkg::WSTAT_BAD;
					err_r <= 1'b1;
					state_r <= wcr_pkg::S_PUMP;
				end else begin
					sda_lo_r <= 1'b1;
				end
				wcr_pkg::Q3: begin
					scl_lo_r <= 1'b1;
					sh_r <= addr_r;
					addr_ph_r <= 1'b1;
					state_r <= wcr_pkg::S_BYTE;
				end
				endcase
			end
			wcr_pkg::S_BYTE: if (step) begin
				unique case (phase_r)
				wcr_pkg::Q0: if (bit_r == wcr_pkg::BIT_ACK) begin
					sda_lo_r <= rd_r && !last;
				end else begin
					sda_lo_r <= !rd_r && !sh_r[7];
				end
				wcr_pkg::Q1: scl_lo_r <= 1'b0;
				wcr_pkg::Q2: if (bit_r == wcr_pkg::BIT_ACK) begin
					if (!rd_r) nack_r <= sda_s_r;
				end else if (rd_r) begin
					sh_r <= {sh_r[6:0], sda_s_r};
				end
				wcr_pkg::Q3: begin
					scl_lo_r <= 1'b1;
					if (bit_r != wcr_pkg::BIT_ACK) begin
						bit_r <= bit_r + 4'h1;
						if (!rd_r) sh_r <= {sh_r[6:0], 1'b0};
					end else begin
						bit_r <= wcr_pkg::BIT_FIRST;
						if (addr_ph_r) begin
							addr_ph_r <= 1'b0;
							if (nack_r) begin
								status_r[wcr_pkg::ST_ADDR] <= 1'b1;
								wstat_r <= wcr_pkg::WSTAT_BAD;
								err_r <= 1'b1;
								state_r <= wcr_pkg::S_STOP;
							end else begin
								rd_r <= is_rd;
								sh_r <= buf_mem[0];
							end
						end else if (rd_r) begin
							cnt_r <= cnt_inc;
							if (last) state_r <= wcr_pkg::S_STOP;
						end else begin
							cnt_r <= cnt_inc;
							sh_r <= buf_mem[cnt_inc];
							if (nack_r) begin
								wstat_r <= cnt_inc;
								state_r <= wcr_pkg::S_STOP;
							end else if (last) begin
								state_r <= cmd_r == wcr_pkg::CMD_WR_STOP ?
									wcr_pkg::S_STOP : wcr_pkg::S_PUMP;
							end
						end
					end
				end
				endcase
			end
			wcr_pkg::S_STOP: if (step) begin
				unique case (phase_r)
				wcr_pkg::Q0: sda_lo_r <= 1'b1;
				wcr_pkg::Q1: scl_lo_r <= 1'b0;
				wcr_pkg::Q2: sda_lo_r <= 1'b0;
				wcr_pkg::Q3: state_r <= wcr_pkg::S_PUMP;
				endcase
			end
			// Results drain through the FIFO and stall when it is full
			wcr_pkg::S_PUMP: if (fifo_ready) begin
				pcnt_r <= pcnt_r + wcr_pkg::PCNT_ONE;
				if (pump_last) state_r <= wcr_pkg::S_IDLE;
			end
			wcr_pkg::S_HALT: ;
			endcase
		end
	end

	// Result FIFO toward the link transmitter
	wcr_fifo #(
		.W(wcr_pkg::FIFO_W),
		.D(wcr_pkg::FIFO_D)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(link_rst_ok),
		.in_valid(pump_valid),
		.in_ready(fifo_ready),
		.in_data(pump_word),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);
endmodule : wcr_bridge
`default_nettype wire

//--- common/wcr_pkg.sv
// Constants shared by the wire-to-I2C continue/read bridge
`default_nettype none
package wcr_pkg;
	// Command codes
	localparam logic [7:0] CMD_WR_NOSTOP = 8'h5a;
	localparam logic [7:0] CMD_WR_CONT = 8'h69;
	localparam logic [7:0] CMD_WR_STOP = 8'h78;
	localparam logic [7:0] CMD_RD_STOP = 8'h87;
	// Field values
	localparam logic [7:0] LEN_ZERO = 8'h00;
	localparam logic [7:0] WSTAT_OK = 8'h00;
	localparam logic [7:0] WSTAT_BAD = 8'hff;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] STATUS_CLR = 8'h00;
	// Status byte bit positions
	localparam int ST_CRC = 0;
	localparam int ST_ADDR = 1;
	localparam int ST_START = 3;
	// CRC16, reflected, checked by running residue over sent inverted CRC
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [15:0] CRC_RESID = 16'hb001;
	// I2C timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int I2C_PERIOD_NS = 10000;
	localparam int QTR_CYC = I2C_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
	// Bit engine
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [1:0] Q0 = 2'h0;
	localparam logic [1:0] Q1 = 2'h1;
	localparam logic [1:0] Q2 = 2'h2;
	localparam logic [1:0] Q3 = 2'h3;
	// Buffers
	localparam int BUF_DEPTH = 256;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	localparam logic [8:0] WR_RESULT_LEN = 9'h002;
	localparam logic [8:0] PCNT_ZERO = 9'h000;
	localparam logic [8:0] PCNT_ONE = 9'h001;
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_LEN, S_DATA, S_CRC_LO, S_CRC_HI,
		S_START, S_BYTE, S_STOP, S_PUMP, S_HALT
	} wcr_state_e;
endpackage : wcr_pkg
`default_nettype wire

//--- tb/wcr_i2c_slave.sv
// Behavioural I2C slave that acks, returns a byte ramp and logs events
`default_nettype none
module wcr_i2c_slave (
	input wire logic scl,
	input wire logic sda,
	input var int nack_at,
	output logic pull,
	output int starts,
	output int stops,
	output int macks,
	output logic [7:0] adr,
	output logic [7:0] wlast
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh, rv;
	logic rd = 1'b0;
	logic ackp = 1'b0;
	int bc = 0;
	int slot = 0;
	int rk = 0;
	assign rv = 8'h5c + rk[7:0];
	initial {pull, starts, stops, macks} = '0;
	// Start restarts framing; slot 1 is the address; power-up settling ignored
	always @(negedge sda) if (scl === 1'b1 && $time > 0) begin
		starts++;
		{bc, slot, rk, rd, ackp} = '0;
	end
	always @(posedge sda) if (scl === 1'b1 && $time > 0) stops++;
	// Sample on the rising clock; master answers in read slots
	always @(posedge scl) begin
		if (!ackp) sh = {sh[6:0], sda};
		if (!ackp) bc++;
		if (ackp && rd && slot > 1) macks += int'(!sda);
		if (ackp && rd && slot > 1 && sda) rd = 1'b0;
	end
	// Change the line only while the clock is low
	always @(negedge scl) begin
		if (ackp) {ackp, bc} = '0;
		else if (bc == 8) begin
			ackp = 1'b1;
			slot++;
			if (slot == 1) adr = sh;
			if (slot == 1) rd = sh[0] && nack_at != 0;
			if (slot > 1 && !rd) wlast = sh;
			if (rd && slot > 1) rk++;
		end
		pull = ackp ? !(rd && slot > 1) && slot - 1 != nack_at
			: rd && !rv[7 - bc];
	end
endmodule : wcr_i2c_slave
`default_nettype wire

//--- tb/wcr_bridge_asserts.sv
// Port checker for the wire-to-I2C bridge
`default_nettype none
module wcr_bridge_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link_reset,
	input wire logic rx_valid,
	input wire logic poll_bit,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic busy_out,
	input wire logic error_detected_out
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic [7:0] hi_r;
	logic [7:0] hi_nxt;
	// Released clock length, saturating so idle time cannot wrap
	assign hi_nxt = scl_oe ? 8'h00 : hi_r + 8'(hi_r != 8'hff);
	always_ff @(posedge clk_sys) hi_r <= rst ? 8'h00 : hi_nxt;
	property p_err;
		$fell(error_detected_out) |-> $past(link_reset);
	endproperty
	a_err: assert property (p_err) else $error("error pin fell");
	property p_busy;
		$changed({scl_oe, sda_oe}) |-> poll_bit;
	endproperty
	a_busy: assert property (p_busy) else $error("poll not busy");
	property p_done;
		$fell(busy_out) |-> !poll_bit && (tx_valid || $past(link_reset));
	endproperty
	a_done: assert property (p_done) else $error("poll not done");
	property p_rx;
		busy_out && rx_valid |=> busy_out;
	endproperty
	a_rx: assert property (p_rx) else $error("byte taken in exec");
	property p_lrst;
		busy_out && link_reset |=> busy_out && $stable(error_detected_out);
	endproperty
	a_lrst: assert property (p_lrst) else $error("reset taken");
	property p_scl;
		$rose(scl_oe) |-> hi_r >= 8'h60;
	endproperty
	a_scl: assert property (p_scl) else $error("clock high short");
	property p_od;
		scl_out == 1'b0 && sda_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_tx;
		tx_valid && !tx_ready && !link_reset |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx: assert property (p_tx) else $error("result byte lost");
	property p_exec;
		$changed({scl_oe, sda_oe}) |->
			(busy_out || $past(busy_out)) or (##[1:2] busy_out);
	endproperty
	a_exec: assert property (p_exec) else $error("bus moved idle");
	c_done: cover property ($fell(busy_out));
	c_err: cover property ($rose(error_detected_out));
	c_take: cover property (tx_valid && tx_ready);
endmodule : wcr_bridge_asserts
bind wcr_bridge wcr_bridge_asserts chk_u (.clk_sys(clk_sys), .rst(rst),
	.link_reset(link_reset), .rx_valid(rx_valid), .poll_bit(poll_bit),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
	.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
	.sda_oe(sda_oe), .busy_out(busy_out),
	.error_detected_out(error_detected_out));
`default_nettype wire

//--- tb/wcr_bridge_bench.sv
// Self-checking bench for the wire-to-I2C bridge
`default_nettype none
module wcr_bridge_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, rst, link_reset, rx_valid, tx_ready, pull;
	logic [7:0] rx_data, tx_data, adr, wlast;
	logic poll_bit, tx_valid, scl_oe, sda_oe, busy_out, error_detected_out;
	int starts, stops, macks, nack_at;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	wire scl;
	wire sda;
	// Open-drain lines with pull-ups; an undriven enable reads as released
	assign scl = !(scl_oe === 1'b1);
	assign sda = !(sda_oe === 1'b1 || pull === 1'b1);
	wcr_bridge dut_u (.clk_sys(clk_sys), .rst(rst), .link_reset(link_reset),
		.rx_valid(rx_valid), .rx_data(rx_data), .poll_bit(poll_bit),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .busy_out(busy_out),
		.error_detected_out(error_detected_out));
	wcr_i2c_slave sl_u (.scl(scl), .sda(sda), .nack_at(nack_at),
		.pull(pull), .starts(starts), .stops(stops), .macks(macks),
		.adr(adr), .wlast(wlast));
	task automatic chk8(logic [7:0] g, logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chk1(logic g, logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask : chk1
	task automatic chkn(int g, int e);
		chk8(8'(g), 8'(e));
	endtask : chkn
	task automatic send(logic [7:0] b);
		@(posedge clk_sys);
		#2 rx_valid = 1'b1;
		rx_data = b;
		@(posedge clk_sys);
		#2 rx_valid = 1'b0;
	endtask : send
	// Reflected CRC16 as the host forms it
	function automatic logic [15:0] crc16(logic [7:0] q[$]);
		logic [15:0] c;
		c = wcr_pkg::CRC_INIT;
		foreach (q[i])
			for (int b = 0; b < 8; b++)
				c = (c[0] ^ q[i][b]) ? (c >> 1) ^ wcr_pkg::CRC_POLY : c >> 1;
		return c;
	endfunction : crc16
	// Inverted CRC goes low byte first; bad flips one bit
	task automatic pkt(logic [7:0] q[$], logic bad);
		logic [15:0] c;
		c = ~crc16(q) ^ {15'h0000, bad};
		foreach (q[i]) send(q[i]);
		send(c[7:0]);
		send(c[15:8]);
	endtask : pkt
	task automatic wt(logic v);
		int n;
		n = 0;
		while (busy_out !== v && n < 70000) begin
			@(posedge clk_sys);
			#2 n++;
		end
	endtask : wt
	// Execution: a stray byte and link reset must both be dropped
	task automatic run();
		wt(1'b1);
		chk1(poll_bit, 1'b1);
		@(posedge clk_sys);
		#2 rx_valid = 1'b1;
		rx_data = 8'h78;
		link_reset = 1'b1;
		@(posedge clk_sys);
		#2 rx_valid = 1'b0;
		link_reset = 1'b0;
		wt(1'b0);
		@(posedge clk_sys);
		#2 chk1(poll_bit, 1'b0);
	endtask : run
	task automatic rd(logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk_sys);
		#2;
		while (tx_valid !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#2 n++;
		end
		chk8(tx_data, e);
		tx_ready = 1'b1;
		@(posedge clk_sys);
		#2 tx_ready = 1'b0;
	endtask : rd
	task automatic lrst();
		send(8'h00);
		@(posedge clk_sys);
		#2 link_reset = 1'b1;
		@(posedge clk_sys);
		#2 link_reset = 1'b0;
	endtask : lrst
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Hang guard; the full run needs about 85000 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 100000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		{rst, link_reset, rx_valid, tx_ready, rx_data} = 12'h800;
		nack_at = -1;
		repeat (20) @(posedge clk_sys);
		#2 rst = 1'b0;
		repeat (8) @(posedge clk_sys);
		// Open write of one byte, left without stop
		pkt('{8'h5a, 8'h50, 8'h01, 8'h11}, 1'b0);
		run();
		rd(8'h00);
		rd(8'h00);
		chkn(starts * 16 + stops, 16);
		chk8(adr, 8'h50);
		// Continuation: data only, no start or stop
		pkt('{8'h69, 8'h02, 8'h22, 8'h33}, 1'b0);
		run();
		rd(8'h00);
		rd(8'h00);
		chkn(starts * 16 + stops, 16);
		chk8(wlast, 8'h33);
		// Closing write refused by the slave; stop still follows
		nack_at = 4;
		pkt('{8'h78, 8'h01, 8'h44}, 1'b0);
		run();
		rd(8'h00);
		rd(8'h01);
		chkn(starts * 16 + stops, 17);
		chk1(error_detected_out, 1'b0);
		nack_at = -1;
		// Corrupt CRC: no bus activity at all
		pkt('{8'h78, 8'h01, 8'h55}, 1'b1);
		rd(8'h01);
		rd(8'hff);
		chkn(starts * 16 + stops, 17);
		chk1(error_detected_out, 1'b1);
		lrst();
		chk1(error_detected_out, 1'b0);
		// Zero length halts parsing until link reset
		pkt('{8'h69, 8'h00}, 1'b0);
		chk8({6'h00, error_detected_out, tx_valid}, 8'h02);
		lrst();
		chk1(error_detected_out, 1'b0);
		// Sixteen-byte read; host stalls so the FIFO fills and refuses
		pkt('{8'h87, 8'h51, 8'h10}, 1'b0);
		run();
		repeat (40) @(posedge clk_sys);
		rd(8'h00);
		for (int i = 0; i < 16; i++) rd(8'h5c + 8'(i));
		@(posedge clk_sys);
		#2 chk1(tx_valid, 1'b0);
		chkn(starts * 16 + stops, 34);
		chk8(adr, 8'h51);
		chkn(macks, 15);
		// Address refused: flag, stop, error pin
		nack_at = 0;
		pkt('{8'h87, 8'h53, 8'h01}, 1'b0);
		run();
		rd(8'h02);
		chkn(starts * 16 + stops, 51);
		chk1(error_detected_out, 1'b1);
		wrap_up();
	end
endmodule : wcr_bridge_bench
`default_nettype wire
